// >>> sim/irq_routing_cpu_sideband_bench.sv
`timescale 1ns/1ps
`default_nettype none

module irq_routing_cpu_sideband_bench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, cpu_type_strap, clock_stop_request_n, isa_irq9, rtc_irq_pin_i;
  logic        nmi_req, system_mgmt_interrupt_req, intr_req, init_req, cpu_reset_req, ed;
  logic        rtc_irq, sci_irq, smbus_irq, ext_level, init_seen, reset_seen, chk_on;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        rtc_irq_pin_o, rtc_irq_pin_oe, nmi_out, system_mgmt_interrupt_n, intr_out;
  logic        cpu_init_out, cpu_reset_out, rtc_irq_pin_to_pic, irq9_to_pic, irq9_level_only;
  logic        irq9_shared, general_input_six, irq_out;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, r, q;
  logic [3:0]  s_axi_wstrb, pci_interrupt_line_n;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [5:0]  m, s;
  logic [33:0] e_q[$], m_q[$];
  int          bad_count, comparisons, cyc, seed, k;
  wire  [11:0] pins = {nmi_out, system_mgmt_interrupt_n, intr_out, init_seen, reset_seen,
                       rtc_irq_pin_to_pic, irq9_to_pic, irq9_level_only, irq9_shared,
                       general_input_six, rtc_irq_pin_oe, irq_out};

  // Short hold keeps the clock-stop scenario brief
  irqrt_top #(.HOLD_CYCLES(8), .NUM_PCI(4)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cpu_type_strap, .clock_stop_request_n, .isa_irq9,
    .rtc_irq_pin_i, .rtc_irq_pin_o, .rtc_irq_pin_oe, .pci_interrupt_line_n, .nmi_req,
    .system_mgmt_interrupt_req, .intr_req, .init_req, .cpu_reset_req, .rtc_irq, .sci_irq,
    .smbus_irq, .nmi_out, .system_mgmt_interrupt_n, .intr_out, .cpu_init_out, .cpu_reset_out,
    .rtc_irq_pin_to_pic, .irq9_to_pic, .irq9_level_only, .irq9_shared, .general_input_six, .irq_out);

  irqrt_cpu_model i_cpu (.strap(cpu_type_strap), .cpu_init_out, .cpu_reset_out,
    .pin_o(rtc_irq_pin_o), .pin_oe(rtc_irq_pin_oe), .ext_level, .init_seen, .reset_seen,
    .pin_level(rtc_irq_pin_i));

  // 200 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task take(input logic [33:0] seen);
    logic [33:0] e;
    logic [33:0] mk;
    e  = e_q.pop_front();
    mk = m_q.pop_front();
    check(seen & mk, e & mk);
  endtask

  // Results are matched in order against the notes left by the drivers
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready) take({s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) take({s_axi_bresp, 32'h0000_0000});
    if (chk_on) take({22'h00_0000, pins});
  end

  task final_report;
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      final_report;
    end
  end

  task wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task chk(input logic [11:0] v, input logic [11:0] mk);
    e_q.push_back({22'h00_0000, v});
    m_q.push_back({22'h00_0000, mk});
    chk_on <= 1'b1;
    @(posedge aclk);
    chk_on <= 1'b0;
    @(posedge aclk);
  endtask

  // Address and data offered together, each dropped once taken; extra edge avoids re-entry race
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
    e_q.push_back({rs, 32'h0000_0000});
    m_q.push_back({2'h3, 32'h0000_0000});
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
    e_q.push_back({rs, d});
    m_q.push_back({2'h3, 32'hFFFF_FFFF});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Strap is set before release since the design freezes it just after reset
  task rst(input logic st);
    aresetn        <= 1'b0;
    cpu_type_strap <= st;
    {nmi_req, system_mgmt_interrupt_req, intr_req, init_req, cpu_reset_req} <= 5'h00;
    wt(16);
    aresetn <= 1'b1;
    wt(6);
  endtask

  // Main sequence
  initial
  begin
    seed = 32'h2f6f;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, chk_on} <= 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 48'h0000_0000_0000;
    s_axi_wstrb <= 4'hF;
    {isa_irq9, rtc_irq, sci_irq, smbus_irq, ext_level} <= 5'h00;
    clock_stop_request_n <= 1'b1;
    pci_interrupt_line_n <= 4'hF;
    rst(1'b0);
    for (k = 0; k < 6; k++) if (k != 3) rd(8'(k * 4), 32'h0000_0000, 2'h0);
    wr(8'h20, 32'hFFFF_FFFF, 2'h3);
    rd(8'h20, 32'h0000_0000, 2'h3);
    for (k = 0; k < 6; k++)
    begin
      r = $random(seed);
      {nmi_req, system_mgmt_interrupt_req, intr_req, init_req, cpu_reset_req} <= r[4:0];
      clock_stop_request_n <= r[5];
      wt(4);
      chk({r[4], ~r[3], r[2], r[1], r[0], 7'h00}, 12'hF80);
    end
    clock_stop_request_n <= 1'b1;
    wr(8'h00, 32'h0000_0001, 2'h0);
    for (k = 0; k < 2; k++)
    begin
      rtc_irq <= k[0];
      wt(4);
      chk({5'h00, k[0], 6'h00}, 12'h042);
    end
    wr(8'h04, 32'h0000_4000, 2'h0);
    for (k = 0; k < 2; k++)
    begin
      ext_level <= k[0];
      wt(5);
      chk({9'h000, k[0], 2'h0}, 12'h006);
    end
    wr(8'h04, 32'h0000_4002, 2'h0);
    rtc_irq <= 1'b1;
    wt(4);
    chk(12'h042, 12'h046);
    wr(8'h04, 32'h0000_0002, 2'h0);
    rd(8'h04, 32'h0000_0002, 2'h0);
    wr(8'h00, 32'h0000_0000, 2'h0);
    for (k = 0; k < 2; k++)
    begin
      ext_level <= k[0];
      wt(5);
      chk({5'h00, ~k[0], 6'h00}, 12'h046);
    end
    // First two passes leave IRQ9 to the ISA pin in both modes, the rest route at random
    for (k = 0; k < 12; k++)
    begin
      r  = $random(seed);
      q  = $random(seed);
      m  = (k < 2) ? 6'h00 : r[5:0];
      ed = (k < 2) ? k[0] : r[6];
      s  = q[5:0];
      wr(8'h08, {23'h00_0000, ed, m[5:2], 2'h0, m[1:0]}, 2'h0);
      {sci_irq, smbus_irq, isa_irq9} <= {s[0], s[1], q[6]};
      pci_interrupt_line_n <= ~s[5:2];
      wt(5);
      chk({6'h00, (|m) ? |(s & m) : q[6], (|m) | !ed, ($countones({m[1:0], |m[5:2]}) > 1), 3'h0},
          12'h038);
    end
    wr(8'h08, 32'h0000_0000, 2'h0);
    {sci_irq, smbus_irq, isa_irq9} <= 3'h0;
    pci_interrupt_line_n <= 4'hF;
    wt(6);
    wr(8'h10, 32'h0000_000F, 2'h0);
    rd(8'h10, 32'h0000_0000, 2'h0);
    isa_irq9 <= 1'b1;
    wt(6);
    rd(8'h10, 32'h0000_0001, 2'h0);
    chk(12'h000, 12'h001);
    wr(8'h14, 32'h0000_0001, 2'h0);
    rd(8'h14, 32'h0000_0001, 2'h0);
    chk(12'h001, 12'h001);
    wr(8'h10, 32'h0000_0001, 2'h0);
    wt(2);
    chk(12'h000, 12'h001);
    rd(8'h10, 32'h0000_0000, 2'h0);
    rst(1'b1);
    {init_req, cpu_reset_req} <= 2'h3;
    wt(4);
    chk(12'h580, 12'hF80);
    {init_req, cpu_reset_req} <= 2'h0;
    clock_stop_request_n <= 1'b0;
    wt(6);
    nmi_req <= 1'b1;
    wt(1);
    nmi_req <= 1'b0;
    wt(4);
    chk(12'hC00, 12'hF80);
    clock_stop_request_n <= 1'b1;
    wt(4);
    chk(12'hC00, 12'hF80);
    wt(20);
    chk(12'h400, 12'hF80);
    final_report;
  end
endmodule // irq_routing_cpu_sideband_bench

`default_nettype wire

// >>> sim/irqrt_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module irqrt_cpu_model (
  input  wire logic strap,
  input  wire logic cpu_init_out,
  input  wire logic cpu_reset_out,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic ext_level,
  output logic      init_seen,
  output logic      reset_seen,
  output logic      pin_level
);
  // Processor decodes init and reset by its own type, so polarity slips show as wrong levels
  assign init_seen  = strap ? ~cpu_init_out : cpu_init_out;
  assign reset_seen = strap ? ~cpu_reset_out : cpu_reset_out;
  // RTC_IRQ_PIN wire: device drive wins, else the external clock source sets the level
  assign pin_level  = pin_oe ? pin_o : ext_level;
endmodule // irqrt_cpu_model

`default_nettype wire

// >>> verilog/irqrt_defs.svh
`ifndef IRQRT_DEFS_SVH
`define IRQRT_DEFS_SVH

// Register byte offsets
`define IRQRT_OFF_RTC_CFG    8'h00
`define IRQRT_OFF_GEN_CFG    8'h04
`define IRQRT_OFF_ROUTE      8'h08
`define IRQRT_OFF_STATE      8'h0C
`define IRQRT_OFF_INT_STAT   8'h10
`define IRQRT_OFF_INT_MASK   8'h14

// Field positions
`define IRQRT_RTC_EN_BIT     0
`define IRQRT_GEN_APIC_BIT   1
`define IRQRT_GEN_GPI_BIT    14
`define IRQRT_RT_SCI_BIT     0
`define IRQRT_RT_SMB_BIT     1
`define IRQRT_RT_PCI_LSB     4
`define IRQRT_RT_EDGE_BIT    8

// Reset values
`define IRQRT_RST_RTC_CFG    1'b0
`define IRQRT_RST_GEN_CFG    16'h0000
`define IRQRT_RST_ROUTE      9'h000
`define IRQRT_RST_INT        4'h0

// Interrupt status bits
`define IRQRT_EV_IRQ9        0
`define IRQRT_EV_RTC_IRQ_PIN        1
`define IRQRT_EV_HOLD        2
`define IRQRT_EV_CONFLICT    3
`define IRQRT_NUM_EV         4

// Post clock-stop hold: 5 PCI clocks, PCI period and core period in ps
`define IRQRT_HOLD_PCI_CLKS  5
`define IRQRT_PCI_PERIOD_PS  30000
`define IRQRT_CLK_PERIOD_PS  5000
`define IRQRT_HOLD_CYCLES \
  ((`IRQRT_HOLD_PCI_CLKS * `IRQRT_PCI_PERIOD_PS + `IRQRT_CLK_PERIOD_PS - 1) \
   / `IRQRT_CLK_PERIOD_PS)

// Strap capture delay after reset release, covers the synchroniser
`define IRQRT_STRAP_WAIT     2'h3

// AXI responses
`define IRQRT_RESP_OKAY      2'h0
`define IRQRT_RESP_DECERR    2'h3

`endif

// >>> verilog/irqrt_pkg.sv
package irqrt_pkg;
  // Sideband conditioning around clock-stop
  typedef enum logic [1:0] {
    IRQRT_PASS,
    IRQRT_STOPPED,
    IRQRT_HOLD
  } irqrt_hold_state_t;

  // Order of the four processor sideband requests
  typedef struct packed {
    logic nmi;
    logic smi;
    logic intr;
    logic init;
  } irqrt_side_t;
endpackage

// >>> verilog/irqrt_sync.sv
`timescale 1ns/1ps
`default_nettype none

module irqrt_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // Two flops per bit; the first is read only by the second
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    logic meta_reg;
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        meta_reg    <= 1'b0;
        sync_out[i] <= 1'b0;
      end
      else
      begin
        meta_reg    <= async_in[i];
        sync_out[i] <= meta_reg;
      end
    end
  end

endmodule // irqrt_sync

`default_nettype wire

// >>> verilog/irqrt_top.sv
// Summary of operation
// [R1] Strap low: sideband requests pass unlatched always
// [R2] Strap high: latch during stop, hold 5 PCI clocks
// [R3] Strap high: init/reset active low, else high
// [R4] Internal clock interrupt feeds RTC_IRQ_PIN internally
// [R5] Config bit 14 makes RTC_IRQ_PIN pin general input; here ignored while the pin is driven for the APIC (R6)
// [R6] Internal clock with APIC: drive RTC_IRQ_PIN pin out
// [R7] Internal source on IRQ9 ignores ISA IRQ9
// [R8] Internal IRQ9 sources force level-only mode
// [R9] No internal source: ISA IRQ9, programmed mode
// [R10] Several internal sources share IRQ9 line
// [R11] Shared IRQ9 is OR of routed requests
`include "irqrt_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module irqrt_top #(
  parameter int HOLD_CYCLES = `IRQRT_HOLD_CYCLES,
  parameter int NUM_PCI     = 4
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Pins
  input  wire logic                 cpu_type_strap,
  input  wire logic                 clock_stop_request_n,
  input  wire logic                 isa_irq9,
  input  wire logic                 rtc_irq_pin_i,
  output logic                      rtc_irq_pin_o,
  output logic                      rtc_irq_pin_oe,
  input  wire logic [NUM_PCI-1:0]   pci_interrupt_line_n,
  // Internal sources, same clock
  input  wire logic                 nmi_req,
  input  wire logic                 system_mgmt_interrupt_req,
  input  wire logic                 intr_req,
  input  wire logic                 init_req,
  input  wire logic                 cpu_reset_req,
  input  wire logic                 rtc_irq,
  input  wire logic                 sci_irq,
  input  wire logic                 smbus_irq,
  // Processor side
  output logic                      nmi_out,
  output logic                      system_mgmt_interrupt_n,
  output logic                      intr_out,
  output logic                      cpu_init_out,
  output logic                      cpu_reset_out,
  // Interrupt controller side
  output logic                      rtc_irq_pin_to_pic,
  output logic                      irq9_to_pic,
  output logic                      irq9_level_only,
  output logic                      irq9_shared,
  output logic                      general_input_six,
  output logic                      irq_out
);

  localparam int PINS = 4 + NUM_PCI;

  logic [PINS-1:0]              pin_sync;
  logic                         strap_sync;
  logic                         stop_sync;
  logic                         irq9_pin_sync;
  logic                         rtc_irq_pin_pin_sync;
  logic [NUM_PCI-1:0]           pci_sync_n;

  logic                         strap_reg;
  logic [1:0]                   strap_cnt_reg;
  logic                         rtc_cfg_reg;
  logic [15:0]                  gen_cfg_reg;
  logic [8:0]                   route_reg;
  logic [`IRQRT_NUM_EV-1:0]     int_stat_reg;
  logic [`IRQRT_NUM_EV-1:0]     int_mask_reg;
  logic [`IRQRT_NUM_EV-1:0]     ev_next;

  irqrt_pkg::irqrt_hold_state_t hold_state_reg;
  logic [15:0]                  hold_cnt_reg;
  irqrt_pkg::irqrt_side_t       live_req;
  irqrt_pkg::irqrt_side_t       held_reg;
  irqrt_pkg::irqrt_side_t       side_next;
  logic                         rst_held_reg;
  logic                         rst_next;

  logic                         apic_drive;
  logic                         gpi_mode;
  logic                         irq9_routed;
  logic                         irq9_internal;
  logic [2:0]                   src_on;
  logic                         irq9_next;
  logic                         rtc_irq_pin_next;

  logic [7:0]                   awaddr_reg;
  logic [31:0]                  wdata_reg;
  logic [3:0]                   wstrb_reg;
  logic [31:0]                  wmask;
  logic                         do_write;
  logic [31:0]                  rd_mux;
  logic                         rd_hit;

  // Every pin crosses two flops before use
  irqrt_sync #(.WIDTH(PINS)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({pci_interrupt_line_n, rtc_irq_pin_i, isa_irq9,
                clock_stop_request_n, cpu_type_strap}),
    .sync_out (pin_sync)
  );

  assign strap_sync    = pin_sync[0];
  assign stop_sync     = ~pin_sync[1];
  assign irq9_pin_sync = pin_sync[2];
  assign rtc_irq_pin_pin_sync = pin_sync[3];
  assign pci_sync_n    = pin_sync[PINS-1:4];

  // Strap is caught once, after the synchroniser has settled past reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      strap_reg     <= 1'b0;
      strap_cnt_reg <= 2'h0;
    end
    else if (strap_cnt_reg != `IRQRT_STRAP_WAIT)
    begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      strap_reg     <= strap_sync;
    end
  end

  assign live_req = '{nmi: nmi_req, smi: system_mgmt_interrupt_req,
                      intr: intr_req, init: init_req};

  // Clock-stop hold machine; only runs with the strap high
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hold_state_reg <= irqrt_pkg::IRQRT_PASS;
      hold_cnt_reg   <= 16'h0000;
      held_reg       <= '0;
      rst_held_reg   <= 1'b0;
    end
    else
    begin
      case (hold_state_reg)
        irqrt_pkg::IRQRT_PASS:
        begin
          if (strap_reg && stop_sync) // R2
          begin
            hold_state_reg <= irqrt_pkg::IRQRT_STOPPED;
            held_reg       <= live_req;
            rst_held_reg   <= cpu_reset_req;
          end
        end
        irqrt_pkg::IRQRT_STOPPED:
        begin
          // Requests arriving while stopped are kept, not dropped
          held_reg     <= held_reg | live_req; // R2
          rst_held_reg <= rst_held_reg | cpu_reset_req;
          if (!stop_sync)
          begin
            hold_state_reg <= irqrt_pkg::IRQRT_HOLD;
            hold_cnt_reg   <= 16'(HOLD_CYCLES - 1); // R2
          end
        end
        irqrt_pkg::IRQRT_HOLD:
        begin
          if (stop_sync)
            hold_state_reg <= irqrt_pkg::IRQRT_STOPPED;
          else if (hold_cnt_reg == 16'h0000)
            hold_state_reg <= irqrt_pkg::IRQRT_PASS;
          else
            hold_cnt_reg <= hold_cnt_reg - 16'h0001;
        end
        default:
          hold_state_reg <= irqrt_pkg::IRQRT_PASS;
      endcase
    end
  end

  // Strap low never leaves PASS, so requests flow straight through
  assign side_next = (hold_state_reg == irqrt_pkg::IRQRT_PASS) ? live_req : held_reg; // R1 R2
  assign rst_next  = (hold_state_reg == irqrt_pkg::IRQRT_PASS) ? cpu_reset_req
                                                               : rst_held_reg;

  // Processor outputs; init and reset polarity follow the strap
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nmi_out                 <= 1'b0;
      system_mgmt_interrupt_n <= 1'b1;
      intr_out                <= 1'b0;
      cpu_init_out            <= 1'b0;
      cpu_reset_out           <= 1'b0;
    end
    else
    begin
      nmi_out                 <= side_next.nmi;
      system_mgmt_interrupt_n <= ~side_next.smi;
      intr_out                <= side_next.intr;
      cpu_init_out            <= side_next.init ^ strap_reg; // R3
      cpu_reset_out           <= rst_next ^ strap_reg; // R3
    end
  end

  // RTC_IRQ_PIN pin direction and internal routing
  assign apic_drive = rtc_cfg_reg && gen_cfg_reg[`IRQRT_GEN_APIC_BIT];
  // Output use wins: a pin driven for the APIC can never be read as input
  assign gpi_mode   = gen_cfg_reg[`IRQRT_GEN_GPI_BIT] && !apic_drive; // R5 R6
  assign rtc_irq_pin_next  = rtc_cfg_reg ? rtc_irq : (!gpi_mode && !rtc_irq_pin_pin_sync); // R4

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rtc_irq_pin_to_pic       <= 1'b0;
      rtc_irq_pin_o     <= 1'b1;
      rtc_irq_pin_oe    <= 1'b0;
      general_input_six <= 1'b0;
    end
    else
    begin
      rtc_irq_pin_to_pic       <= rtc_irq_pin_next; // R4
      rtc_irq_pin_o     <= ~rtc_irq; // R6
      rtc_irq_pin_oe    <= apic_drive; // R6
      general_input_six <= gpi_mode & rtc_irq_pin_pin_sync; // R5
    end
  end

  // IRQ9 source selection
  assign src_on[0]     = route_reg[`IRQRT_RT_SCI_BIT];
  assign src_on[1]     = route_reg[`IRQRT_RT_SMB_BIT];
  assign src_on[2]     = |route_reg[`IRQRT_RT_PCI_LSB +: NUM_PCI];
  assign irq9_routed   = |src_on;
  assign irq9_internal = (src_on[0] & sci_irq) | (src_on[1] & smbus_irq)
                       | |(route_reg[`IRQRT_RT_PCI_LSB +: NUM_PCI] & ~pci_sync_n); // R11
  assign irq9_next     = irq9_routed ? irq9_internal : irq9_pin_sync; // R7 R9

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq9_to_pic     <= 1'b0;
      irq9_level_only <= 1'b1;
      irq9_shared     <= 1'b0;
    end
    else
    begin
      irq9_to_pic     <= irq9_next; // R7 R9
      irq9_level_only <= irq9_routed || !route_reg[`IRQRT_RT_EDGE_BIT]; // R8 R9
      irq9_shared     <= (src_on[0] & src_on[1]) | (src_on[0] & src_on[2])
                       | (src_on[1] & src_on[2]); // R10
    end
  end

  // Events: request edges, hold entry, illegal pin setup
  assign ev_next[`IRQRT_EV_IRQ9]     = irq9_next && !irq9_to_pic;
  assign ev_next[`IRQRT_EV_RTC_IRQ_PIN]     = rtc_irq_pin_next && !rtc_irq_pin_to_pic
                                     && strap_cnt_reg == `IRQRT_STRAP_WAIT;
  assign ev_next[`IRQRT_EV_HOLD]     = (hold_state_reg == irqrt_pkg::IRQRT_PASS)
                                     && strap_reg && stop_sync;
  assign ev_next[`IRQRT_EV_CONFLICT] = apic_drive && gen_cfg_reg[`IRQRT_GEN_GPI_BIT];

  // AXI write: address and data taken in any order, then one response
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wmask    = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                     {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `IRQRT_RESP_OKAY;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        case (awaddr_reg)
          `IRQRT_OFF_RTC_CFG, `IRQRT_OFF_GEN_CFG, `IRQRT_OFF_ROUTE,
          `IRQRT_OFF_STATE, `IRQRT_OFF_INT_STAT, `IRQRT_OFF_INT_MASK:
            s_axi_bresp <= `IRQRT_RESP_OKAY;
          default:
            s_axi_bresp <= `IRQRT_RESP_DECERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Configuration registers, byte strobes honoured
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rtc_cfg_reg  <= `IRQRT_RST_RTC_CFG;
      gen_cfg_reg  <= `IRQRT_RST_GEN_CFG;
      route_reg    <= `IRQRT_RST_ROUTE;
      int_mask_reg <= `IRQRT_RST_INT;
    end
    else if (do_write)
    begin
      case (awaddr_reg)
        `IRQRT_OFF_RTC_CFG:
          if (wstrb_reg[0])
            rtc_cfg_reg <= wdata_reg[`IRQRT_RTC_EN_BIT];
        `IRQRT_OFF_GEN_CFG:
          gen_cfg_reg <= (gen_cfg_reg & ~wmask[15:0]) | (wdata_reg[15:0] & wmask[15:0]);
        `IRQRT_OFF_ROUTE:
          route_reg <= (route_reg & ~wmask[8:0]) | (wdata_reg[8:0] & wmask[8:0]);
        `IRQRT_OFF_INT_MASK:
          if (wstrb_reg[0])
            int_mask_reg <= wdata_reg[`IRQRT_NUM_EV-1:0];
        default:
          int_mask_reg <= int_mask_reg;
      endcase
    end
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      int_stat_reg <= `IRQRT_RST_INT;
    else if (do_write && awaddr_reg == `IRQRT_OFF_INT_STAT && wstrb_reg[0])
      int_stat_reg <= (int_stat_reg & ~wdata_reg[`IRQRT_NUM_EV-1:0]) | ev_next;
    else
      int_stat_reg <= int_stat_reg | ev_next;
  end

  // Level interrupt from unmasked status, one cycle behind the status
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_out <= 1'b0;
    else
      irq_out <= |(int_stat_reg & int_mask_reg);
  end

  // Read data selection
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `IRQRT_OFF_RTC_CFG:  rd_mux[0] = rtc_cfg_reg;
      `IRQRT_OFF_GEN_CFG:  rd_mux[15:0] = gen_cfg_reg;
      `IRQRT_OFF_ROUTE:    rd_mux[8:0] = route_reg;
      `IRQRT_OFF_STATE:
        rd_mux[7:0] = {irq9_shared, irq9_level_only, irq9_routed, gpi_mode,
                       apic_drive, hold_state_reg != irqrt_pkg::IRQRT_PASS,
                       stop_sync, strap_reg};
      `IRQRT_OFF_INT_STAT: rd_mux[`IRQRT_NUM_EV-1:0] = int_stat_reg;
      `IRQRT_OFF_INT_MASK: rd_mux[`IRQRT_NUM_EV-1:0] = int_mask_reg;
      default:             rd_hit = 1'b0;
    endcase
  end

  // AXI read: one outstanding, data one cycle after the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `IRQRT_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_hit ? `IRQRT_RESP_OKAY : `IRQRT_RESP_DECERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_pass_unlatched;
    !strap_reg && $stable(strap_reg) |=> nmi_out == $past(nmi_req)
      && intr_out == $past(intr_req) && cpu_init_out == $past(init_req);
  endproperty
  a_pass_unlatched: assert property (p_pass_unlatched) // R1
    else $error("Sideband not passed through with strap low");

  property p_hold_len;
    hold_state_reg == irqrt_pkg::IRQRT_STOPPED && !stop_sync
      |=> hold_state_reg == irqrt_pkg::IRQRT_HOLD
          && hold_cnt_reg == 16'(HOLD_CYCLES - 1);
  endproperty
  a_hold_len: assert property (p_hold_len) // R2
    else $error("Hold count not loaded on clock-stop release");

  property p_hold_keeps;
    hold_state_reg != irqrt_pkg::IRQRT_PASS && $past(hold_state_reg) != irqrt_pkg::IRQRT_PASS
      |=> nmi_out == $past(held_reg.nmi);
  endproperty
  a_hold_keeps: assert property (p_hold_keeps) // R2
    else $error("Latched request not presented during hold");

  property p_polarity;
    hold_state_reg == irqrt_pkg::IRQRT_PASS && $stable(strap_reg)
      |=> cpu_reset_out == ($past(strap_reg) ? !$past(cpu_reset_req) : $past(cpu_reset_req));
  endproperty
  a_polarity: assert property (p_polarity) // R3
    else $error("Reset output polarity does not follow strap");

  property p_rtc_internal;
    rtc_cfg_reg |=> rtc_irq_pin_to_pic == $past(rtc_irq);
  endproperty
  a_rtc_internal: assert property (p_rtc_internal) // R4
    else $error("Internal clock interrupt not on RTC_IRQ_PIN");

  property p_gpi;
    gen_cfg_reg[`IRQRT_GEN_GPI_BIT] && !apic_drive
      |=> general_input_six == $past(rtc_irq_pin_pin_sync) && !rtc_irq_pin_oe;
  endproperty
  a_gpi: assert property (p_gpi) // R5
    else $error("RTC_IRQ_PIN pin not acting as general input");

  property p_apic_drive;
    apic_drive |=> rtc_irq_pin_oe && !general_input_six && rtc_irq_pin_o == !$past(rtc_irq);
  endproperty
  a_apic_drive: assert property (p_apic_drive) // R6
    else $error("RTC_IRQ_PIN pin not driven for external APIC");

  property p_isa_ignored;
    irq9_routed |=> irq9_to_pic == $past(irq9_internal) && irq9_level_only;
  endproperty
  a_isa_ignored: assert property (p_isa_ignored) // R7
    else $error("ISA IRQ9 not ignored or not level-only");

  property p_isa_used;
    !irq9_routed |=> irq9_to_pic == $past(irq9_pin_sync)
      && irq9_level_only == !$past(route_reg[`IRQRT_RT_EDGE_BIT]);
  endproperty
  a_isa_used: assert property (p_isa_used) // R9
    else $error("ISA IRQ9 not used in programmed mode");

  property p_shared;
    src_on[0] && src_on[1] |=> irq9_shared;
  endproperty
  a_shared: assert property (p_shared) // R10
    else $error("Shared flag missing for two sources");

endmodule // irqrt_top

`default_nettype wire
